// *** rtl/asmc_ctrl.sv ***
// Purpose: Host controller driving a 64K x 32 asynchronous memory module
// Assumes: Pins sampled synchronous to ref_clk; one request at a time
// Notes:   One shared down counter times every bus phase
// Functional notes
// - Write spans overlap of select and write strobe; framed inside it
// - Write strobe held high throughout every read
// - Select and write strobe low at least 15 ns before write end
// - Address stable 15 ns before write end; may change at end
// - Address held until write end, hold 0 ns
// - Address-driven read keeps selects low, changes only address; not used here, selects rise at the end of every read
// - Address valid no later than last select asserting
// - Select deasserted before supply drops to retention
// - One read cycle after supply returns before any access; code waits 20 ns in both grades, under the 45 ns slow read cycle
`timescale 1ns/10ps
module asmc_ctrl #(
  parameter bit FAST_GRADE = 1'b1
) (
  // Clock, reset, enable
  input  wire logic                     ref_clk,
  input  wire logic                     sys_rst,
  input  wire logic                     clk_en,
  // Request side
  input  wire logic                     req_valid,
  input  wire asmc_pkg::asmc_op_t       req_op,
  input  wire logic [asmc_pkg::ADDR_W-1:0] req_addr,
  input  wire logic [asmc_pkg::DATA_W-1:0] req_wdata,
  input  wire logic [asmc_pkg::LANES-1:0]  req_lanes,
  output logic                          req_ready,
  output logic                          rsp_valid,
  output logic [asmc_pkg::DATA_W-1:0]   rsp_rdata,
  // Memory pins
  output logic [asmc_pkg::ADDR_W-1:0]   addr_lines,
  output logic [asmc_pkg::LANES-1:0]    byte_lane_select_n,
  output logic                          write_strobe_n,
  output logic                          output_drive_n,
  input  wire logic [asmc_pkg::DATA_W-1:0] data_lines_in,
  output logic [asmc_pkg::DATA_W-1:0]   data_lines_out,
  output logic                          data_lines_oe,
  // Supply control
  output logic                          retention_req
);
  import asmc_pkg::*;

  localparam int RD_CYC = ns_up(FAST_GRADE ? READ_CYCLE_MIN_NS : SLOW_READ_CYCLE_NS);
  localparam int WR_PW  = ns_up(FAST_GRADE ? WRITE_PULSE_MIN_NS : SLOW_WRITE_PULSE_NS);
  localparam int WR_CYC = ns_up(FAST_GRADE ? WRITE_CYCLE_MIN_NS : SLOW_WRITE_CYCLE_NS);
  localparam int TOFF   = ns_up(FAST_GRADE ? SELECT_TURN_OFF_NS : SLOW_TURN_OFF_NS);
  localparam int REC    = ns_up(RETENTION_RECOVERY_NS);
  localparam logic [CNT_W-1:0] RD_CNT  = CNT_W'(RD_CYC - 1);
  localparam logic [CNT_W-1:0] WR_CNT  = CNT_W'(WR_PW - 1);
  localparam logic [CNT_W-1:0] GAP_CNT = CNT_W'(((WR_CYC > WR_PW + 1) ? WR_CYC - WR_PW : 1) - 1);
  localparam logic [CNT_W-1:0] OFF_CNT = CNT_W'(TOFF - 1);
  localparam logic [CNT_W-1:0] REC_CNT = CNT_W'(REC - 1);

  typedef enum logic [2:0] {
    ASMC_IDLE,
    ASMC_RD,
    ASMC_WR,
    ASMC_WR_GAP,
    ASMC_OFF,
    ASMC_SLEEP,
    ASMC_WAKE
  } asmc_state_t;

  asmc_state_t state_reg;
  asmc_timer_if tif ();

  asmc_timer u_timer (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .clk_en  (clk_en),
    .tif     (tif)
  );

  function automatic logic accept(input logic v, input asmc_state_t s, input logic d);
    return v && s == ASMC_IDLE && d;
  endfunction

  logic take;
  assign take = accept(req_valid, state_reg, tif.done) && clk_en;

  // Timer loads
  always_comb begin
    tif.load  = 1'b0;
    tif.count = '0;
    if (take) begin
      tif.load = 1'b1;
      unique case (req_op)
        ASMC_OP_READ:  tif.count = RD_CNT;
        ASMC_OP_WRITE: tif.count = WR_CNT;
        ASMC_OP_SLEEP: tif.count = '0;
        default:       tif.count = REC_CNT;
      endcase
    end else if (clk_en && tif.done) begin
      case (state_reg)
        ASMC_RD: begin
          tif.load  = 1'b1;
          tif.count = OFF_CNT;
        end
        ASMC_WR: begin
          tif.load  = 1'b1;
          tif.count = GAP_CNT;
        end
        ASMC_SLEEP: begin
          if (req_valid && req_op == ASMC_OP_WAKE) begin
            tif.load  = 1'b1;
            tif.count = REC_CNT;
          end
        end
        default: tif.load = 1'b0;
      endcase
    end
  end

  // Sequencer
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_reg <= ASMC_IDLE;
    end else if (clk_en) begin
      case (state_reg)
        ASMC_IDLE: if (take) begin
          case (req_op)
            ASMC_OP_READ:  state_reg <= ASMC_RD;
            ASMC_OP_WRITE: state_reg <= ASMC_WR;
            ASMC_OP_SLEEP: state_reg <= ASMC_SLEEP;
            default:       state_reg <= ASMC_IDLE;
          endcase
        end
        ASMC_RD:     if (tif.done) state_reg <= ASMC_OFF;
        ASMC_WR:     if (tif.done) state_reg <= ASMC_WR_GAP;
        ASMC_WR_GAP: if (tif.done) state_reg <= ASMC_IDLE;
        ASMC_OFF:    if (tif.done) state_reg <= ASMC_IDLE;
        ASMC_SLEEP:  if (req_valid && req_op == ASMC_OP_WAKE) state_reg <= ASMC_WAKE;
        ASMC_WAKE:   if (tif.done) state_reg <= ASMC_IDLE;
        default:     state_reg <= ASMC_IDLE;
      endcase
    end
  end

  // Address and lane selects set together with the start
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      addr_lines         <= '0;
      byte_lane_select_n <= '1;
    end else if (clk_en) begin
      if (take && (req_op == ASMC_OP_READ || req_op == ASMC_OP_WRITE)) begin
        addr_lines         <= req_addr;
        byte_lane_select_n <= ~req_lanes;
      end else if ((state_reg == ASMC_RD || state_reg == ASMC_WR) && tif.done) begin
        byte_lane_select_n <= '1;
      end
    end
  end

  // Strobes
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      write_strobe_n <= 1'b1;
      output_drive_n <= 1'b1;
    end else if (clk_en) begin
      if (take && req_op == ASMC_OP_WRITE) begin
        // No strobe without a selected lane
        write_strobe_n <= (req_lanes == '0);
      end else if (state_reg == ASMC_WR && tif.done) begin
        write_strobe_n <= 1'b1;
      end
      if (take && req_op == ASMC_OP_READ) begin
        output_drive_n <= 1'b0;
      end else if (state_reg == ASMC_RD && tif.done) begin
        output_drive_n <= 1'b1;
      end
    end
  end

  // Write data; held through the terminating edge
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      data_lines_out <= '0;
      data_lines_oe  <= 1'b0;
    end else if (clk_en) begin
      if (take && req_op == ASMC_OP_WRITE) begin
        data_lines_out <= req_wdata;
        data_lines_oe  <= 1'b1;
      end else if (state_reg == ASMC_WR_GAP) begin
        data_lines_oe  <= 1'b0;
      end
    end
  end

  // Read capture at end of access time
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
    end else if (clk_en) begin
      rsp_valid <= 1'b0;
      if (state_reg == ASMC_RD && tif.done) begin
        rsp_valid <= 1'b1;
        rsp_rdata <= data_lines_in;
      end
    end
  end

  // Retention and ready
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      retention_req <= 1'b0;
      req_ready     <= 1'b0;
    end else if (clk_en) begin
      if (state_reg == ASMC_SLEEP) begin
        retention_req <= 1'b1;
      end else if (state_reg == ASMC_WAKE) begin
        retention_req <= 1'b0;
      end
      req_ready <= (state_reg == ASMC_IDLE) && tif.done && !take;
    end
  end

  sequence s_wr_start;
    take && req_op == ASMC_OP_WRITE;
  endsequence

  a_read_strobe_high: assert property (@(posedge ref_clk iff clk_en) disable iff (sys_rst)
    !output_drive_n |-> write_strobe_n)
    else $error("write strobe low during read");
  a_write_pulse_len: assert property (@(posedge ref_clk iff clk_en) disable iff (sys_rst)
    $fell(write_strobe_n) |-> !write_strobe_n [*2])
    else $error("write pulse too short");
  a_write_select: assert property (@(posedge ref_clk iff clk_en) disable iff (sys_rst)
    !write_strobe_n |-> byte_lane_select_n != '1)
    else $error("write strobe outside select");
  a_write_data_held: assert property (@(posedge ref_clk iff clk_en) disable iff (sys_rst)
    $rose(write_strobe_n) |-> data_lines_oe && $stable(data_lines_out))
    else $error("write data not held at end");
  a_addr_stable_wr: assert property (@(posedge ref_clk iff clk_en) disable iff (sys_rst)
    (!write_strobe_n && $past(!write_strobe_n)) |-> $stable(addr_lines))
    else $error("address moved in write");
  a_no_drive_clash: assert property (@(posedge ref_clk iff clk_en) disable iff (sys_rst)
    !(data_lines_oe && !output_drive_n))
    else $error("bus contention");
  a_read_spacing: assert property (@(posedge ref_clk iff clk_en) disable iff (sys_rst)
    $fell(output_drive_n) |-> !output_drive_n [*2] ##1 output_drive_n)
    else $error("read cycle length wrong");
  a_write_gap: assert property (@(posedge ref_clk iff clk_en) disable iff (sys_rst)
    s_wr_start |=> !s_wr_start [*3])
    else $error("writes too close");
  a_retention_desel: assert property (@(posedge ref_clk iff clk_en) disable iff (sys_rst)
    retention_req |-> byte_lane_select_n == '1)
    else $error("selected in retention");
endmodule

// *** rtl/asmc_pkg.sv ***
// Purpose: Constants for the asynchronous memory module controller
// Assumes: 100 MHz ref_clk, 10 ns period
// Notes:   Times in ns; cycle counts derived from them
package asmc_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int ADDR_W        = 16;
  localparam int DATA_W        = 32;
  localparam int LANES         = 4;
  // Fastest grade
  localparam int READ_CYCLE_MIN_NS       = 20;
  localparam int ADDR_TO_DATA_MAX_NS     = 20;
  localparam int SELECT_TURN_OFF_NS      = 9;
  localparam int DRIVE_OFF_NS            = 7;
  localparam int WRITE_CYCLE_MIN_NS      = 20;
  localparam int WRITE_PULSE_MIN_NS      = 15;
  localparam int DATA_SETUP_MIN_NS       = 10;
  localparam int RETENTION_RECOVERY_NS   = READ_CYCLE_MIN_NS;
  // Slow grade alternative
  localparam int SLOW_READ_CYCLE_NS      = 45;
  localparam int SLOW_WRITE_CYCLE_NS     = 35;
  localparam int SLOW_WRITE_PULSE_NS     = 25;
  localparam int SLOW_TURN_OFF_NS        = 18;

  function automatic int ns_up(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int CNT_W = 4;

  typedef enum logic [1:0] {
    ASMC_OP_READ,
    ASMC_OP_WRITE,
    ASMC_OP_SLEEP,
    ASMC_OP_WAKE
  } asmc_op_t;
endpackage

// *** rtl/asmc_timer.sv ***
// Purpose: Down counter that times each bus phase
// Assumes: Synchronous active-high reset
// Notes:   done is high while count is zero
`timescale 1ns/10ps
module asmc_timer (
  // Clock and reset
  input  wire logic  ref_clk,
  input  wire logic  sys_rst,
  input  wire logic  clk_en,
  // Controller side
  asmc_timer_if.timer tif
);
  import asmc_pkg::*;
  logic [CNT_W-1:0] cnt_reg;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cnt_reg <= '0;
    end else if (clk_en) begin
      if (tif.load) begin
        cnt_reg <= tif.count;
      end else if (cnt_reg != '0) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end

  // Plain count compare; load already depends on done in the controller
  assign tif.done = (cnt_reg == '0);
endmodule

// *** rtl/asmc_timer_if.sv ***
// Purpose: Carries load and done between controller and its timer
// Assumes: Single clock domain
// Notes:   Count is in clock cycles
`timescale 1ns/10ps
interface asmc_timer_if;
  import asmc_pkg::*;
  logic             load;
  logic [CNT_W-1:0] count;
  logic             done;
  modport ctrl  (output load, output count, input done);
  modport timer (input load, input count, output done);
endinterface

// *** sim/asmc_mem_model.sv ***
// Purpose: Behavioural 64K x 32 memory module at the controller's far side
// Assumes: Selects and strobes active low; undriven lanes toggle each cycle
// Notes:   viol counts controller pin timing slips
`timescale 1ns/10ps
module asmc_mem_model (
  // Clock for the undriven pattern only
  input  wire logic        ref_clk,
  // Memory pins
  input  wire logic [15:0] addr_lines,
  input  wire logic [3:0]  byte_lane_select_n,
  input  wire logic        write_strobe_n,
  input  wire logic        output_drive_n,
  input  wire logic        retention_req,
  input  wire logic [31:0] data_bus,
  output logic      [31:0] data_q,
  output int               viol
);
  logic [31:0] mem [0:65535];
  logic [31:0] last_q = '0;
  realtime     t_we, t_d, t_a;
  realtime     t_r = -1000.0;
  bit          armed = 1'b0;
  initial viol = 0;
  always @(posedge ref_clk) last_q <= data_q;
  always @* begin
    for (int l = 0; l < 4; l++) begin
      data_q[8*l+:8] = ~last_q[8*l+:8];
      if (write_strobe_n && !output_drive_n && !byte_lane_select_n[l])
        data_q[8*l+:8] = mem[addr_lines][8*l+:8];
      if (!write_strobe_n && !byte_lane_select_n[l])
        mem[addr_lines][8*l+:8] = data_bus[8*l+:8];
    end
  end
  // Controller timing seen at the pins
  always @(data_bus) t_d = $realtime;
  always @(addr_lines) t_a = $realtime;
  always @(negedge write_strobe_n) begin
    t_we = $realtime;
    armed = 1'b1;
  end
  always @(posedge write_strobe_n) if (armed) begin
    armed = 1'b0;
    if ($realtime - t_we < 15.0) viol++;
    if ($realtime - t_d < 10.0) viol++;
    if ($realtime - t_a < 15.0) viol++;
  end
  always @(negedge output_drive_n) if (!write_strobe_n) viol++;
  always @(posedge retention_req) if (byte_lane_select_n !== 4'hf) viol++;
  // Any select within one read cycle of leaving retention is a slip
  always @(negedge retention_req) t_r = $realtime;
  always @(byte_lane_select_n)
    if (byte_lane_select_n !== 4'hf && $realtime - t_r < 20.0) viol++;
endmodule

// *** sim/async_sram_module_timing_tb.sv ***
// Purpose: Self-checking bench for the memory module controller
// Assumes: Inputs driven at the falling edge; reset held 16 cycles
// Notes:   Reference memory is an associative array of words
`timescale 1ns/10ps
module async_sram_module_timing_tb;
  import asmc_pkg::*;
  logic        ref_clk = 1'b0, sys_rst = 1'b1, clk_en = 1'b1, req_valid = 1'b0;
  asmc_op_t    req_op = ASMC_OP_READ;
  logic [15:0] req_addr = '0, addr;
  logic [31:0] req_wdata = '0, rsp_rdata, dout, dq, bus;
  logic [3:0]  req_lanes = 4'hf, sel_n;
  logic        req_ready, rsp_valid, we_n, od_n, oe, ret;
  int          failures = 0, n_checks = 0, viol, cyc = 0;
  bit          rnd_en = 1'b0;
  logic [31:0] ref_mem [int];
  logic [31:0] exp_q [$];
  logic [3:0]  msk_q [$];
  logic [15:0] al [$];
  always #5 ref_clk = ~ref_clk;
  assign bus = oe ? dout : dq;
  asmc_ctrl #(.FAST_GRADE(1'b1)) uut (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .req_valid(req_valid), .req_op(req_op), .req_addr(req_addr), .req_wdata(req_wdata),
    .req_lanes(req_lanes), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .addr_lines(addr), .byte_lane_select_n(sel_n),
    .write_strobe_n(we_n), .output_drive_n(od_n), .data_lines_in(bus),
    .data_lines_out(dout), .data_lines_oe(oe), .retention_req(ret));
  asmc_mem_model mdl (.ref_clk(ref_clk), .addr_lines(addr), .byte_lane_select_n(sel_n),
    .write_strobe_n(we_n), .output_drive_n(od_n), .retention_req(ret), .data_bus(bus),
    .data_q(dq), .viol(viol));
  function automatic logic [31:0] lmask(logic [3:0] l);
    return {{8{l[3]}}, {8{l[2]}}, {8{l[1]}}, {8{l[0]}}};
  endfunction
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Waits for ready with valid low (wake skips the wait), then offers the request for one enabled edge
  task automatic req(asmc_op_t op, logic [15:0] a, logic [31:0] d, logic [3:0] l);
    logic [31:0] w;
    do begin
      if (rnd_en) clk_en = ($urandom % 4) != 0;
      @(negedge ref_clk);
    end while (op != ASMC_OP_WAKE && req_ready !== 1'b1);
    req_op = op;
    req_addr = a;
    req_wdata = d;
    req_lanes = l;
    req_valid = 1'b1;
    clk_en = 1'b1;
    @(negedge ref_clk);
    req_valid = 1'b0;
    if (op == ASMC_OP_WRITE) begin
      w = ref_mem.exists(a) ? ref_mem[a] : 'x;
      for (int i = 0; i < 4; i++) if (l[i]) w[8*i+:8] = d[8*i+:8];
      ref_mem[a] = w;
    end
    if (op == ASMC_OP_READ) begin
      exp_q.push_back(ref_mem[a]);
      msk_q.push_back(l);
    end
  endtask
  task automatic wait_ret(logic v);
    for (int i = 0; i < 20 && ret !== v; i++) @(negedge ref_clk);
    check("retention_req", 32'(ret), 32'(v));
  endtask
  always @(posedge ref_clk) if (rsp_valid === 1'b1 && clk_en) begin
    if (exp_q.size() == 0)
      check("rsp_extra", 32'h1, 32'h0);
    else
      check("rsp_rdata", rsp_rdata & lmask(msk_q[0]), exp_q.pop_front() & lmask(msk_q.pop_front()));
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      test_done();
    end
  end
  initial begin
    void'($urandom(97));
    repeat (16) @(negedge ref_clk);
    check("reset_pins", {22'h0, sel_n, we_n, od_n, oe, rsp_valid, ret, req_ready}, {22'h0, 4'hf, 6'b110000});
    sys_rst = 1'b0;
    al = '{16'h0000, 16'hffff};
    repeat (8) al.push_back(16'($urandom));
    foreach (al[i]) req(ASMC_OP_WRITE, al[i], $urandom, 4'hf);
    foreach (al[i]) req(ASMC_OP_READ, al[i], '0, 4'hf);
    for (int m = 0; m < 16; m++) begin
      req(ASMC_OP_WRITE, al[m % 10], $urandom, 4'(m));
      req(ASMC_OP_READ, al[m % 10], '0, 4'hf);
      req(ASMC_OP_READ, al[(m + 3) % 10], '0, 4'($urandom));
    end
    rnd_en = 1'b1;
    repeat (30) begin
      if ($urandom % 2) req(ASMC_OP_WRITE, al[$urandom % 10], $urandom, 4'($urandom));
      else req(ASMC_OP_READ, al[$urandom % 10], '0, 4'hf);
    end
    rnd_en = 1'b0;
    clk_en = 1'b1;
    req(ASMC_OP_WAKE, al[0], '0, 4'hf);
    req(ASMC_OP_SLEEP, al[0], '0, 4'hf);
    wait_ret(1'b1);
    check("sleep_pins", {27'h0, sel_n, we_n}, {27'h0, 4'hf, 1'b1});
    req(ASMC_OP_WAKE, al[0], '0, 4'hf);
    wait_ret(1'b0);
    req(ASMC_OP_READ, al[1], '0, 4'hf);
    req(ASMC_OP_WRITE, al[2], $urandom, 4'hf);
    req(ASMC_OP_READ, al[2], '0, 4'hf);
    repeat (12) @(negedge ref_clk);
    check("rsp_missing", 32'(exp_q.size()), 32'h0);
    check("pin_timing", 32'(viol), 32'h0);
    test_done();
  end
endmodule
